// file: hw/sensor_fifo_pkg.sv
// Purpose: constants and types shared by the motion sensor output buffer
// Assumes: byte-wide register port, six 16-bit channels per sample
// Notes: addresses are byte sub-addresses of the register port
package sensor_fifo_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned CH_W = 16;
  localparam int unsigned N_CH = 6;
  localparam int unsigned DEPTH = 32;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;

  // ==========================================================================
  // register sub-addresses
  localparam logic [7:0] ADDR_EVENT_PIN_ONE_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_GYRO_X_OUTPUT = 8'h18;
  localparam logic [7:0] ADDR_GYRO_Z_OUTPUT_HI = 8'h1d;
  localparam logic [7:0] ADDR_CONTROL_FOUR = 8'h1e;
  localparam logic [7:0] ADDR_CONTROL_EIGHT = 8'h22;
  localparam logic [7:0] ADDR_CONTROL_NINE = 8'h23;
  localparam logic [7:0] ADDR_ACCEL_EVENT_SOURCE = 8'h26;
  localparam logic [7:0] ADDR_ACCEL_X_OUTPUT = 8'h28;
  localparam logic [7:0] ADDR_ACCEL_Z_OUTPUT = 8'h2c;
  localparam logic [7:0] ADDR_ACCEL_Z_OUTPUT_HI = 8'h2d;
  localparam logic [7:0] ADDR_BUFFER_CONTROL = 8'h2e;
  localparam logic [7:0] ADDR_BUFFER_STATUS = 8'h2f;

  // ==========================================================================
  // field positions
  localparam int unsigned BIT_WATERMARK_IRQ_ROUTE = 3;
  localparam int unsigned BIT_THRESHOLD_IRQ_ENABLE = 4;
  localparam int unsigned BIT_FULL_IRQ_ENABLE = 5;
  localparam int unsigned BIT_ACCEL_EVENT_LATCH = 1;
  localparam int unsigned BIT_ADDR_AUTO_INC = 2;
  localparam int unsigned BIT_HALT_AT_WATERMARK = 0;
  localparam int unsigned BIT_BUFFER_ENABLE = 1;
  localparam int unsigned BIT_ACCEL_EVENT_ACTIVE = 6;
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned STATUS_WM_BIT = 7;
  localparam int unsigned STATUS_OVR_BIT = 6;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_EVENT_PIN_ONE_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONTROL_FOUR = 8'h00;
  localparam logic [7:0] RST_CONTROL_EIGHT = 8'h04;
  localparam logic [7:0] RST_CONTROL_NINE = 8'h00;
  localparam logic [7:0] RST_BUFFER_CONTROL = 8'h00;

  // ==========================================================================
  // buffer_mode_select codes
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_STOP_FULL = 3'h1;
  localparam logic [2:0] MODE_CONT_THEN_STOP = 3'h3;
  localparam logic [2:0] MODE_BYPASS_THEN_CONT = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h6;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    RUN_BYPASS = 3'b001,
    RUN_STOP = 3'b010,
    RUN_CONT = 3'b100
  } run_mode_t;

  // channel 0..2 gyro x,y,z; 3..5 accel x,y,z
  typedef logic [N_CH-1:0][CH_W-1:0] sample_t;

  typedef struct packed {
    logic start;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    sample_t [1:0] skid_q;
    logic [1:0] skid_cnt;
    logic skid_head;
    sample_t [DEPTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic overrun;
    logic [7:0] event_ctrl;
    logic [7:0] ctrl_four;
    logic [7:0] ctrl_eight;
    logic [7:0] ctrl_nine;
    logic [7:0] buf_ctrl;
    logic [7:0] sub_addr;
    logic [7:0] rdata;
    logic event_pin;
    run_mode_t mode;
  } fifo_state_t;

endpackage

// file: hw/motion_sensor_output_fifo.sv
// Purpose: six-channel sample buffer with modes, flags, event pin and burst read-out
// Assumes: serial protocol decoded elsewhere into the byte register port
// Notes: one sample is popped when the high byte of the accel z output is read

module motion_sensor_output_fifo
  import sensor_fifo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic gyro_active,
  input wire logic accel_event_active,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire sample_t sample_data,
  output logic event_pin_one
);

  // ==========================================================================
  // helpers
  function automatic logic [7:0] sample_byte(input sample_t smp, input logic [3:0] idx);
    logic [CH_W-1:0] ch;
    ch = smp[idx[3:1]];
    if (idx[0]) begin
      sample_byte = ch[15:8];
    end else begin
      sample_byte = ch[7:0];
    end
  endfunction

  // wraps at 32 slots through the pointer's own width
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 5'h01;
  endfunction

  // true when the address falls inside one sensor's six output bytes
  function automatic logic in_span(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  // a zero level disables the flag rather than making it always true
  function automatic logic watermark_hit(input logic [CNT_W-1:0] c, input logic [4:0] lvl);
    watermark_hit = 1'b0;
    if (lvl != 5'h00) begin
      watermark_hit = (c >= {1'b0, lvl});
    end
  endfunction

  // usable depth: the full 32 slots, or the watermark level plus one
  function automatic logic [CNT_W-1:0] depth_limit(input logic halt, input logic [4:0] lvl);
    if (halt) begin
      depth_limit = {1'b0, lvl} + 6'h01;
    end else begin
      depth_limit = CNT_FULL;
    end
  endfunction

  // a disabled buffer or an unknown code falls back to bypass, so stale
  // samples are never reported after a bad write
  function automatic run_mode_t decode_mode(input logic en, input logic [2:0] code,
                                            input logic evt);
    decode_mode = RUN_BYPASS;
    if (en) begin
      case (code)
        MODE_STOP_FULL: begin
          decode_mode = RUN_STOP;
        end
        MODE_CONTINUOUS: begin
          decode_mode = RUN_CONT;
        end
        MODE_CONT_THEN_STOP: begin
          decode_mode = evt ? RUN_STOP : RUN_CONT;
        end
        MODE_BYPASS_THEN_CONT: begin
          decode_mode = evt ? RUN_CONT : RUN_BYPASS;
        end
        default: begin
          decode_mode = RUN_BYPASS;
        end
      endcase
    end
  endfunction

  // burst pointer: wraps after the accel z high byte, to accel x while gyro_active is low so a host can stream
  // accel-only samples without resending the sub-address, and to gyro x while it is high; gyro z high runs on to 0x1e
  function automatic logic [7:0] next_sub_addr(input logic [7:0] a, input logic inc,
                                               input logic gyro);
    next_sub_addr = a;
    if (inc) begin
      if (a == ADDR_ACCEL_Z_OUTPUT_HI) begin
        if (gyro) begin
          next_sub_addr = ADDR_GYRO_X_OUTPUT;
        end else begin
          next_sub_addr = ADDR_ACCEL_X_OUTPUT;
        end
      end else begin
        next_sub_addr = a + 8'h01;
      end
    end
  endfunction

  function automatic logic [7:0] status_byte(input logic wm, input logic ovr,
                                             input logic [CNT_W-1:0] c);
    status_byte = 8'h00;
    status_byte[STATUS_WM_BIT] = wm;
    status_byte[STATUS_OVR_BIT] = ovr;
    status_byte[CNT_W-1:0] = c;
  endfunction

  // slot that an incoming sample lands in: behind the head when one entry
  // waits, at the head otherwise; a same-cycle drain moves the head first
  function automatic logic skid_slot(input logic hd, input logic [1:0] n, input logic dr);
    skid_slot = hd ^ dr;
    if (n == 2'h1 && !dr) begin
      skid_slot = ~hd;
    end
  endfunction

  // only the event-active bit is modelled; the other source bits read zero
  function automatic logic [7:0] event_source_byte(input logic act);
    event_source_byte = 8'h00;
    event_source_byte[BIT_ACCEL_EVENT_ACTIVE] = act;
  endfunction

  // ==========================================================================
  // state
  fifo_state_t s_ff;
  fifo_state_t nxt_s;

  logic [7:0] acc_addr;
  logic [7:0] rd_byte;
  logic [7:0] off_gyro;
  logic [7:0] off_accel;
  logic [2:0] sel_mode;
  logic [4:0] wm_level;
  logic [CNT_W-1:0] depth_lim;
  logic [CNT_W-1:0] cnt;
  logic [PTR_W-1:0] rp;
  logic [PTR_W-1:0] wp;
  logic wm_flag;
  logic full_flag;
  logic drain;
  logic pop;
  logic ovr_set;
  logic stopped_mode;
  logic push_in;
  logic push_idx;
  sample_t head;
  sample_t view;
  logic stat_rd;
  logic pin_wm;
  logic pin_thr;
  logic pin_full;

  assign sample_ready = (s_ff.skid_cnt != 2'h2);
  assign reg_rdata = s_ff.rdata;
  assign event_pin_one = s_ff.event_pin;

  always_comb begin
    nxt_s = s_ff;
    acc_addr = reg_req.start ? reg_req.addr : s_ff.sub_addr;
    sel_mode = s_ff.buf_ctrl[MODE_LSB +: 3];
    wm_level = s_ff.buf_ctrl[4:0];
    depth_lim = depth_limit(s_ff.ctrl_nine[BIT_HALT_AT_WATERMARK], wm_level);
    wm_flag = watermark_hit(s_ff.count, wm_level);
    // full means at the usable depth, which halt-at-watermark may shrink
    full_flag = (s_ff.count >= depth_lim);
    stopped_mode = (s_ff.mode == RUN_STOP);
    stat_rd = reg_req.rd && (acc_addr == ADDR_BUFFER_STATUS);

    // ========================================================================
    // read view: bypass shows slot zero, otherwise the oldest unread entry
    if (s_ff.mode == RUN_BYPASS) begin
      view = s_ff.mem[0];
    end else begin
      view = s_ff.mem[s_ff.rd_ptr];
    end
    off_gyro = acc_addr - ADDR_GYRO_X_OUTPUT;
    off_accel = acc_addr - ADDR_ACCEL_X_OUTPUT;
    rd_byte = 8'h00;
    if (in_span(acc_addr, ADDR_GYRO_X_OUTPUT, ADDR_GYRO_Z_OUTPUT_HI)) begin
      rd_byte = sample_byte(view, off_gyro[3:0]);
    end else if (in_span(acc_addr, ADDR_ACCEL_X_OUTPUT, ADDR_ACCEL_Z_OUTPUT_HI)) begin
      rd_byte = sample_byte(view, off_accel[3:0] + 4'h6);
    end else begin
      case (acc_addr)
        ADDR_EVENT_PIN_ONE_CONTROL: begin
          rd_byte = s_ff.event_ctrl;
        end
        ADDR_CONTROL_FOUR: begin
          rd_byte = s_ff.ctrl_four;
        end
        ADDR_CONTROL_EIGHT: begin
          rd_byte = s_ff.ctrl_eight;
        end
        ADDR_CONTROL_NINE: begin
          rd_byte = s_ff.ctrl_nine;
        end
        ADDR_ACCEL_EVENT_SOURCE: begin
          rd_byte = event_source_byte(accel_event_active);
        end
        ADDR_BUFFER_CONTROL: begin
          rd_byte = s_ff.buf_ctrl;
        end
        ADDR_BUFFER_STATUS: begin
          rd_byte = status_byte(wm_flag, s_ff.overrun, s_ff.count);
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end
    if (reg_req.rd) begin
      nxt_s.rdata = rd_byte;
    end

    // ========================================================================
    // register writes
    if (reg_req.wr) begin
      case (acc_addr)
        ADDR_EVENT_PIN_ONE_CONTROL: begin
          nxt_s.event_ctrl = reg_req.wdata;
        end
        ADDR_CONTROL_FOUR: begin
          nxt_s.ctrl_four = reg_req.wdata;
        end
        ADDR_CONTROL_EIGHT: begin
          nxt_s.ctrl_eight = reg_req.wdata;
        end
        ADDR_CONTROL_NINE: begin
          nxt_s.ctrl_nine = reg_req.wdata;
        end
        ADDR_BUFFER_CONTROL: begin
          nxt_s.buf_ctrl = reg_req.wdata;
        end
        default: begin
          // read-only and unmapped addresses drop the write
          nxt_s.sub_addr = nxt_s.sub_addr;
        end
      endcase
    end

    // ========================================================================
    // sub-address pointer with burst wrap
    // a start reloads the pointer; reads and writes both advance it
    nxt_s.sub_addr = next_sub_addr(acc_addr,
      (reg_req.rd || reg_req.wr) && s_ff.ctrl_eight[BIT_ADDR_AUTO_INC], gyro_active);

    // ========================================================================
    // two-entry input buffer; it stalls on register reads so that a sample
    // never lands in the same cycle as a pop
    head = s_ff.skid_q[s_ff.skid_head];
    push_in = sample_valid && (s_ff.skid_cnt != 2'h2);
    drain = (s_ff.skid_cnt != 2'h0) && !reg_req.rd;
    push_idx = skid_slot(s_ff.skid_head, s_ff.skid_cnt, drain);
    if (push_in) begin
      nxt_s.skid_q[push_idx] = sample_data;
    end
    if (drain) begin
      nxt_s.skid_head = ~s_ff.skid_head;
    end
    nxt_s.skid_cnt = s_ff.skid_cnt + {1'b0, push_in} - {1'b0, drain};

    // ========================================================================
    // buffer pointers and count
    cnt = s_ff.count;
    rp = s_ff.rd_ptr;
    wp = s_ff.wr_ptr;
    ovr_set = 1'b0;
    // popping on the last byte keeps all six channels of a sample together
    pop = reg_req.rd && (acc_addr == ADDR_ACCEL_Z_OUTPUT_HI) &&
          (s_ff.mode != RUN_BYPASS) && (s_ff.count != 6'h00);
    if (pop) begin
      rp = ptr_inc(rp);
      cnt = cnt - 6'h01;
    end
    case (s_ff.mode)
      RUN_BYPASS: begin
        // pointers stay parked; slot zero keeps only the newest sample
        rp = '0;
        wp = '0;
        cnt = '0;
        if (drain) begin
          nxt_s.mem[0] = head;
        end
      end
      RUN_STOP: begin
        // samples beyond the limit are taken from the input buffer and dropped
        if (drain && cnt < depth_lim) begin
          nxt_s.mem[wp] = head;
          wp = ptr_inc(wp);
          cnt = cnt + 6'h01;
        end
      end
      RUN_CONT: begin
        // a full buffer drops its oldest entry so the newest is always kept
        if (drain) begin
          if (cnt >= depth_lim) begin
            rp = ptr_inc(rp);
            cnt = cnt - 6'h01;
            ovr_set = 1'b1;
          end
          nxt_s.mem[wp] = head;
          wp = ptr_inc(wp);
          cnt = cnt + 6'h01;
        end
      end
      default: begin
        cnt = s_ff.count;
      end
    endcase
    nxt_s.rd_ptr = rp;
    nxt_s.wr_ptr = wp;
    nxt_s.count = cnt;

    // overrun clears on a status read or in bypass; a new overwrite wins
    if (ovr_set) begin
      nxt_s.overrun = 1'b1;
    end else if (stat_rd || s_ff.mode == RUN_BYPASS) begin
      nxt_s.overrun = 1'b0;
    end

    // ========================================================================
    // effective run mode
    nxt_s.mode = decode_mode(s_ff.ctrl_nine[BIT_BUFFER_ENABLE], sel_mode, accel_event_active);

    // ========================================================================
    // event pin; registered so a settling count cannot glitch it
    pin_wm = s_ff.event_ctrl[BIT_WATERMARK_IRQ_ROUTE] && wm_flag;
    pin_thr = s_ff.event_ctrl[BIT_THRESHOLD_IRQ_ENABLE] && stopped_mode && wm_flag;
    pin_full = s_ff.event_ctrl[BIT_FULL_IRQ_ENABLE] && full_flag &&
               (s_ff.mode != RUN_BYPASS);
    nxt_s.event_pin = pin_wm || pin_thr || pin_full;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // registers that do not reset to zero are named one by one
      s_ff <= '0;
      s_ff.event_ctrl <= RST_EVENT_PIN_ONE_CONTROL;
      s_ff.ctrl_four <= RST_CONTROL_FOUR;
      s_ff.ctrl_eight <= RST_CONTROL_EIGHT;
      s_ff.ctrl_nine <= RST_CONTROL_NINE;
      s_ff.buf_ctrl <= RST_BUFFER_CONTROL;
      s_ff.mode <= RUN_BYPASS;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule // motion_sensor_output_fifo

// file: dv/motion_sensor_output_fifo_properties.sv
// Purpose: port-level properties of the motion sensor output buffer
// Assumes: every register write carries its own sub-address (start high)
// Notes: shadows see only start-addressed writes, so auto-increment writes are not tracked
module motion_sensor_output_fifo_properties
  import sensor_fifo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic gyro_active,
  input wire logic accel_event_active,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire sample_t sample_data,
  input wire logic event_pin_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // shadows of the control registers
  logic [7:0] buf_ff;
  logic [7:0] irq_ff;
  logic [7:0] c9_ff;
  logic [2:0] idle_ff;
  logic wr_go;
  logic rd_go;
  logic rd_stat;
  assign wr_go = reg_req.wr && reg_req.start;
  assign rd_go = reg_req.rd && reg_req.start;
  assign rd_stat = rd_go && reg_req.addr == ADDR_BUFFER_STATUS;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_ff <= RST_BUFFER_CONTROL;
      irq_ff <= RST_EVENT_PIN_ONE_CONTROL;
      c9_ff <= RST_CONTROL_NINE;
      idle_ff <= 3'h7;
    end else begin
      if (wr_go && reg_req.addr == ADDR_BUFFER_CONTROL) buf_ff <= reg_req.wdata;
      if (wr_go && reg_req.addr == ADDR_EVENT_PIN_ONE_CONTROL) irq_ff <= reg_req.wdata;
      if (wr_go && reg_req.addr == ADDR_CONTROL_NINE) c9_ff <= reg_req.wdata;
      idle_ff <= {idle_ff[1:0], buf_ff[7:5] == MODE_BYPASS || !c9_ff[BIT_BUFFER_ENABLE]};
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_mode_readback: assert property (
    rd_go && reg_req.addr == ADDR_BUFFER_CONTROL |=> reg_rdata == buf_ff)
    else $error("buffer control read back wrong");
  chk_irq_readback: assert property (
    rd_go && reg_req.addr == ADDR_EVENT_PIN_ONE_CONTROL |=> reg_rdata == irq_ff)
    else $error("event pin control read back wrong");
  chk_enable_readback: assert property (
    rd_go && reg_req.addr == ADDR_CONTROL_NINE |=> reg_rdata == c9_ff)
    else $error("control nine read back wrong");
  chk_count_range: assert property (rd_stat |=> reg_rdata[5:0] <= CNT_FULL)
    else $error("unread count above full");
  chk_wm_flag: assert property (rd_stat |=> reg_rdata[7] ==
    (buf_ff[4:0] != 5'h00 && reg_rdata[5:0] >= {1'b0, buf_ff[4:0]}))
    else $error("watermark flag disagrees with count");
  chk_idle_empty: assert property (rd_stat && &idle_ff |=> reg_rdata[5:0] == 6'h00)
    else $error("idle buffer reports unread samples");
  chk_pin_quiet: assert property (
    irq_ff[5:3] == 3'h0 && $past(irq_ff[5:3]) == 3'h0 |-> !event_pin_one)
    else $error("event pin high with all sources off");
  chk_halt_depth: assert property (rd_stat && c9_ff[BIT_HALT_AT_WATERMARK]
    |=> reg_rdata[5:0] <= {1'b0, buf_ff[4:0]} + 6'h01)
    else $error("count beyond watermark plus one");
  cover property (rd_stat ##1 reg_rdata[5:0] == CNT_FULL);
  cover property ($rose(event_pin_one));
  cover property (sample_valid && !sample_ready);
endmodule // motion_sensor_output_fifo_properties

bind motion_sensor_output_fifo motion_sensor_output_fifo_properties i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .gyro_active(gyro_active), .accel_event_active(accel_event_active),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
  .event_pin_one(event_pin_one));

// file: dv/sensor_host_model.sv
// Purpose: host side of the register port
// Assumes: one access every other cycle, request released after the taking edge
// Notes: idle request is all zero, so no stale address or strobe lingers
module sensor_host_model
  import sensor_fifo_pkg::*;
(
  input wire logic ref_clk,
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // accesses
  initial reg_req = '0;
  task automatic access(input logic w, input logic st, input logic [7:0] a,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    reg_req <= '{start: st, wr: w, rd: !w, addr: a, wdata: wd};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 rd = reg_rdata;
  endtask
endmodule // sensor_host_model

// file: dv/test_motion_sensor_output_fifo.sv
// Purpose: self-checking bench for the motion sensor output buffer
// Assumes: watermark level fixed at four for every row
// Notes: each row restarts from bypass, fills, then bursts two samples out when at least two are buffered
module test_motion_sensor_output_fifo
  import sensor_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] c9;
    logic [2:0] m;
    logic ev;
    logic [7:0] irq;
    logic [7:0] n;
  } row_t;
  localparam int WM = 4;
  localparam logic [7:0] RA [7] = '{8'h0c, 8'h1e, 8'h22, 8'h23, 8'h2e, 8'h2f, 8'h00};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  row_t rows [12] = '{
    {8'h02, 3'h0, 1'b0, 8'h08, 8'd40}, {8'h02, 3'h1, 1'b0, 8'h10, 8'd40},
    {8'h02, 3'h6, 1'b0, 8'h10, 8'd40}, {8'h02, 3'h3, 1'b1, 8'h20, 8'd40},
    {8'h02, 3'h3, 1'b0, 8'h08, 8'd40}, {8'h02, 3'h4, 1'b0, 8'h08, 8'd40},
    {8'h02, 3'h4, 1'b1, 8'h20, 8'd40}, {8'h03, 3'h1, 1'b0, 8'h08, 8'd40},
    {8'h03, 3'h6, 1'b0, 8'h00, 8'd40}, {8'h00, 3'h6, 1'b0, 8'h08, 8'd40},
    {8'h02, 3'h6, 1'b0, 8'h20, 8'd3}, {8'h02, 3'h7, 1'b0, 8'h08, 8'd10}};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic gyro_active = 1'b0;
  logic accel_event_active = 1'b0;
  logic sample_valid = 1'b0;
  sample_t sample_data = '0;
  logic sample_ready;
  logic event_pin_one;
  logic [7:0] reg_rdata;
  reg_req_t reg_req;
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] lfsr = 16'h0c56;
  sample_t pushed[$];
  logic [7:0] got;
  logic [8:0] e;
  motion_sensor_output_fifo i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .gyro_active(gyro_active), .accel_event_active(accel_event_active),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .event_pin_one(event_pin_one));
  sensor_host_model i_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  initial forever #2.5 ref_clk = ~ref_clk;
  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] g, input logic [7:0] x, input string what);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, g, x);
    end
  endtask
  task automatic rd(input logic st, input logic [7:0] a, input logic [7:0] x, input string w);
    i_host.access(1'b0, st, a, 8'h00, got);
    check(got, x, w);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic push();
    sample_t d;
    foreach (d[c]) begin
      lfsr = lfsr_next(lfsr);
      d[c] = lfsr;
    end
    pushed.push_back(d);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge ref_clk);
    while (sample_ready !== 1'b1) @(posedge ref_clk);
  endtask
  // expected {event pin, status byte} after n pushes into a cleared buffer
  function automatic logic [8:0] expect_state(input row_t r);
    int lim;
    int cnt;
    logic cont;
    logic stop;
    logic wm;
    cont = r.c9[BIT_BUFFER_ENABLE] && (r.m == MODE_CONTINUOUS ||
      (r.m == MODE_CONT_THEN_STOP && !r.ev) || (r.m == MODE_BYPASS_THEN_CONT && r.ev));
    stop = r.c9[BIT_BUFFER_ENABLE] && (r.m == MODE_STOP_FULL ||
      (r.m == MODE_CONT_THEN_STOP && r.ev));
    lim = r.c9[BIT_HALT_AT_WATERMARK] ? WM + 1 : DEPTH;
    cnt = (cont || stop) ? (r.n < lim ? int'(r.n) : lim) : 0;
    wm = cnt >= WM;
    return {(r.irq[BIT_WATERMARK_IRQ_ROUTE] && wm) || (r.irq[BIT_THRESHOLD_IRQ_ENABLE] && stop
      && wm) || (r.irq[BIT_FULL_IRQ_ENABLE] && cnt >= lim), wm, cont && r.n > lim, cnt[5:0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    #100000;
    err_total++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict();
  end
  initial begin
    int old;
    int nb;
    logic [5:0] c2;
    sample_t s;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (RA[i]) rd(1'b1, RA[i], RV[i], "reset value");
    $display("reset values done");
    foreach (rows[i]) begin
      @(posedge ref_clk);
      gyro_active <= i[0];
      accel_event_active <= rows[i].ev;
      i_host.access(1'b1, 1'b1, ADDR_BUFFER_CONTROL, 8'h04, got);
      i_host.access(1'b1, 1'b1, ADDR_CONTROL_NINE, rows[i].c9, got);
      i_host.access(1'b1, 1'b1, ADDR_EVENT_PIN_ONE_CONTROL, rows[i].irq, got);
      i_host.access(1'b1, 1'b1, ADDR_BUFFER_CONTROL, {rows[i].m, 5'h04}, got);
      rd(1'b1, ADDR_ACCEL_EVENT_SOURCE, 8'(rows[i].ev) << BIT_ACCEL_EVENT_ACTIVE, "event src");
      pushed.delete();
      @(posedge ref_clk);
      repeat (rows[i].n) push();
      sample_valid <= 1'b0;
      repeat (4) @(posedge ref_clk);
      e = expect_state(rows[i]);
      rd(1'b1, ADDR_BUFFER_STATUS, e[7:0], "status");
      check({7'h00, event_pin_one}, {7'h00, e[8]}, "event pin");
      if (e[5:0] >= 6'd2) begin
        old = e[6] ? int'(rows[i].n) - int'(e[5:0]) : 0;
        nb = i[0] ? 12 : 6;
        for (int k = 0; k < 2 * nb; k++) begin
          s = pushed[old + k / nb];
          rd(k == 0 || (i[0] && k % 12 == 6), (k == 0 && i[0]) ? ADDR_GYRO_X_OUTPUT :
            ADDR_ACCEL_X_OUTPUT, s[(i[0] ? 0 : 3) + (k % nb) / 2][8 * (k % 2) +: 8],
            "burst byte");
        end
        c2 = e[5:0] - 6'd2;
        rd(1'b1, ADDR_BUFFER_STATUS, {c2 >= WM, 1'b0, c2}, "after pop");
      end
      $display("row %0d done", i);
    end
    give_verdict();
  end
endmodule // test_motion_sensor_output_fifo
